// file: hw/ptimer_pkg.sv
// shared constants and types for the 8-bit period timer
package ptimer_pkg;

  // apb register byte addresses, one aligned word each
  localparam logic [11:0] TICK_COUNT_ADDR = 12'h000;
  localparam logic [11:0] PERIOD_VALUE_ADDR = 12'h004;
  localparam logic [11:0] TIMER_CONTROL_ADDR = 12'h008;
  localparam logic [11:0] IRQ_FLAG_ADDR = 12'h00C;

  // reset values
  localparam logic [7:0] TICK_COUNT_RST = 8'h00;
  localparam logic [7:0] PERIOD_VALUE_RST = 8'hFF;
  localparam logic [6:0] TIMER_CONTROL_RST = 7'h00;

  // timer_control field positions
  localparam int PRESCALE_LSB = 0;
  localparam int RUN_BIT_POS = 2;
  localparam int POSTSCALE_LSB = 3;
  localparam int CTRL_USED_BITS = 7;
  // irq flag register field position
  localparam int MATCH_FLAG_POS = 0;

  // prescale select encodings and their terminal counts (ratio minus one)
  localparam logic [1:0] PRESCALE_DIV1 = 2'h0;
  localparam logic [1:0] PRESCALE_DIV4 = 2'h1;
  localparam logic [3:0] PRESCALE_LAST1 = 4'h0;
  localparam logic [3:0] PRESCALE_LAST4 = 4'h3;
  localparam logic [3:0] PRESCALE_LAST16 = 4'hF;

  // timing: pclk is the oscillator, the instruction clock is a quarter of it
  localparam int PCLK_PERIOD_NS = 8;
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] INSTR_PHASE_LAST = 2'(OSC_PER_INSTR - 1);

  // zero word for reads of unmapped space
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // control register fields as carried between processes
  typedef struct packed {
    logic [3:0] postscale_select; // ratio minus one
    logic run_bit;                // timer running
    logic [1:0] prescale_select;  // 1, 4 or 16
  } timer_control_t;

endpackage

// file: hw/tick_prescaler.sv
// instruction clock divider and selectable 1/4/16 prescaler
module tick_prescaler (
  input wire logic pclk,           // oscillator clock
  input wire logic presetn,        // async reset, active low
  input wire logic run,            // timer running
  input wire logic clear,          // clears the prescale counter
  input wire logic [1:0] sel,      // prescale select
  output logic presc_pulse         // one-cycle increment event
);

  logic [1:0] instr_phase_ff;   // free-running quarter divider
  logic [3:0] presc_cnt_ff;     // prescale counter
  logic instr_tick;             // one pclk per instruction cycle
  logic [3:0] presc_last;       // terminal count for the selection

  // decode of the selected ratio; 1x both mean divide by 16
  function automatic logic [3:0] presc_limit(input logic [1:0] s);
    if (s == ptimer_pkg::PRESCALE_DIV1) begin
      return ptimer_pkg::PRESCALE_LAST1;
    end else if (s == ptimer_pkg::PRESCALE_DIV4) begin
      return ptimer_pkg::PRESCALE_LAST4;
    end
    return ptimer_pkg::PRESCALE_LAST16;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_phase_ff <= 2'h0;
    end else begin
      instr_phase_ff <= instr_phase_ff + 2'h1;
    end
  end
  assign instr_tick = (instr_phase_ff == ptimer_pkg::INSTR_PHASE_LAST);
  assign presc_last = presc_limit(sel);

  assign presc_pulse = instr_tick & run & ~clear & (presc_cnt_ff == presc_last);

  // cleared on count and control writes, stalled while stopped; a restart is a control write and so clears the count, not the instruction phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_cnt_ff <= 4'h0;
    end else if (clear) begin
      presc_cnt_ff <= 4'h0;
    end else if (instr_tick && run) begin
      presc_cnt_ff <= presc_pulse ? 4'h0 : presc_cnt_ff + 4'h1;
    end
  end

  chk_instr_rate: assert property (@(posedge pclk) disable iff (!presetn)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction tick not every fourth clock");
  chk_presc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> presc_cnt_ff == 4'h0)
    else $error("prescaler not cleared");

endmodule

// file: hw/match_postscaler.sv
// 1-to-16 postscaler counting period matches
module match_postscaler (
  input wire logic pclk,          // oscillator clock
  input wire logic presetn,       // async reset, active low
  input wire logic clear,         // clears the postscale counter
  input wire logic advance,       // one period match
  input wire logic [3:0] sel,     // ratio minus one
  output logic post_pulse         // one-cycle postscaled output
);

  logic [3:0] post_cnt_ff; // matches seen so far

  // output fires on the match that completes the ratio
  assign post_pulse = advance & ~clear & (post_cnt_ff == sel);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_cnt_ff <= 4'h0;
    end else if (clear) begin
      post_cnt_ff <= 4'h0;
    end else if (advance) begin
      // a ratio lowered below the count wraps through 15 first
      post_cnt_ff <= post_pulse ? 4'h0 : post_cnt_ff + 4'h1;
    end
  end

  chk_post_step: assert property (@(posedge pclk) disable iff (!presetn)
    advance && !clear && post_cnt_ff != sel |=> post_cnt_ff == $past(post_cnt_ff) + 4'h1)
    else $error("postscaler did not advance");
  chk_post_clear: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> post_cnt_ff == 4'h0)
    else $error("postscaler not cleared");

endmodule

// file: hw/period_timer_8bit.sv
// 8-bit period timer with prescaler, postscaler and apb registers
//
// The address map and the APB slave port are this design's own decisions.
module period_timer_8bit (
  input wire logic pclk,             // oscillator clock, 125 MHz
  input wire logic presetn,          // async reset, active low
  input wire logic psel,             // apb select
  input wire logic penable,          // apb access phase
  input wire logic pwrite,           // apb direction, high for write
  input wire logic [11:0] paddr,     // apb byte address
  input wire logic [31:0] pwdata,    // apb write data
  output logic [31:0] prdata,        // apb read data
  output logic pready,               // apb ready, never waits
  output logic pslverr,              // apb error on unmapped address
  output logic match_irq_flag        // sticky match flag
);

  // register state
  // all of these share the one asynchronous reset
  logic [7:0] tick_count_ff;                 // running count
  logic [7:0] period_value_ff;               // period to compare
  ptimer_pkg::timer_control_t ctrl_ff;       // control fields
  logic match_irq_flag_ff;                   // sticky flag
  logic [31:0] prdata_ff;                    // captured read word

  // next values
  logic [7:0] nxt_tick_count;
  logic [7:0] nxt_period_value;
  ptimer_pkg::timer_control_t nxt_ctrl;
  logic nxt_match_irq_flag;
  logic [31:0] nxt_prdata;

  // bus decode
  logic acc_phase;      // access cycle of any transfer
  logic setup_rd;       // setup cycle of a read
  logic wr_fire;        // write takes effect at this edge
  logic wr_tick;        // write to tick_count
  logic wr_period;      // write to period_value
  logic wr_ctrl;        // write to timer_control
  logic wr_flag;        // write to the flag register
  logic addr_ok;        // access address is mapped

  // timing path
  logic scaler_clear;   // clears prescaler and postscaler
  logic presc_pulse;    // one increment event
  logic period_hit;     // count equals period
  logic wrap_evt;       // increment that wraps to zero
  logic post_pulse;     // postscaled match

  // true when the address names one of our word registers
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] base);
    return a == base;
  endfunction

  // ---- apb slave ----

  // the slave never inserts wait states
  // so every access cycle completes and the master never stalls here
  assign pready = 1'b1;
  assign acc_phase = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign addr_ok = reg_hit(paddr, ptimer_pkg::TICK_COUNT_ADDR)
                 | reg_hit(paddr, ptimer_pkg::PERIOD_VALUE_ADDR)
                 | reg_hit(paddr, ptimer_pkg::TIMER_CONTROL_ADDR)
                 | reg_hit(paddr, ptimer_pkg::IRQ_FLAG_ADDR);
  // unmapped addresses answer with an error; writes there are dropped
  assign pslverr = acc_phase & ~addr_ok;
  assign wr_fire = acc_phase & pwrite & pready;
  assign wr_tick = wr_fire & reg_hit(paddr, ptimer_pkg::TICK_COUNT_ADDR);
  assign wr_period = wr_fire & reg_hit(paddr, ptimer_pkg::PERIOD_VALUE_ADDR);
  assign wr_ctrl = wr_fire & reg_hit(paddr, ptimer_pkg::TIMER_CONTROL_ADDR);
  assign wr_flag = wr_fire & reg_hit(paddr, ptimer_pkg::IRQ_FLAG_ADDR);

  // read word is sampled in the setup cycle so prdata comes from a flop;
  // a count that moves during the access cycle shows its older value
  always_comb begin
    nxt_prdata = ptimer_pkg::READ_ZERO;
    if (reg_hit(paddr, ptimer_pkg::TICK_COUNT_ADDR)) begin
      nxt_prdata[7:0] = tick_count_ff;
    end else if (reg_hit(paddr, ptimer_pkg::PERIOD_VALUE_ADDR)) begin
      nxt_prdata[7:0] = period_value_ff;
    end else if (reg_hit(paddr, ptimer_pkg::TIMER_CONTROL_ADDR)) begin
      // bit 7 and above read zero
      nxt_prdata[ptimer_pkg::CTRL_USED_BITS-1:0] = ctrl_ff;
    end else if (reg_hit(paddr, ptimer_pkg::IRQ_FLAG_ADDR)) begin
      nxt_prdata[ptimer_pkg::MATCH_FLAG_POS] = match_irq_flag_ff;
    end
  end

  // read data register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= ptimer_pkg::READ_ZERO;
    end else if (setup_rd) begin
      prdata_ff <= nxt_prdata;
    end
  end
  assign prdata = prdata_ff;

  // ---- control register ----

  // a write to the control word also restarts both scalers, see below
  // run bit, prescale field, postscale field
  always_comb begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl) begin
      // bit 7 of the write word is simply not stored
      nxt_ctrl.prescale_select = pwdata[ptimer_pkg::PRESCALE_LSB +: 2];
      nxt_ctrl.run_bit = pwdata[ptimer_pkg::RUN_BIT_POS];
      nxt_ctrl.postscale_select = pwdata[ptimer_pkg::POSTSCALE_LSB +: 4];
    end
  end

  // control flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= ptimer_pkg::timer_control_t'(ptimer_pkg::TIMER_CONTROL_RST);
    end else begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // ---- prescaler ----

  // the instruction phase is not cleared, so a restart lands within one
  // instruction cycle of the write; only the scale counters are reset
  // scalers restart on count or control writes; reset clears them too
  assign scaler_clear = wr_tick | wr_ctrl;

  // the prescaler sees run and select straight from the flops
  tick_prescaler u_prescaler (
    .pclk(pclk),
    .presetn(presetn),
    .run(ctrl_ff.run_bit),
    .clear(scaler_clear),
    .sel(ctrl_ff.prescale_select),
    .presc_pulse(presc_pulse)
  );

  // ---- counter and comparator ----

  // comparator looks at the live count every cycle
  assign period_hit = (tick_count_ff == period_value_ff);
  // a match only counts on an increment event; an idle match just waits
  assign wrap_evt = presc_pulse & period_hit;

  // control writes leave the count
  // software write has priority over a same-cycle increment
  always_comb begin
    nxt_tick_count = tick_count_ff;
    if (wr_tick) begin
      nxt_tick_count = pwdata[7:0];
    end else if (wrap_evt) begin
      // match turns the next increment into a load of zero
      nxt_tick_count = ptimer_pkg::TICK_COUNT_RST;
    end else if (presc_pulse) begin
      // plain increment; a period below the count rolls past FFh
      nxt_tick_count = tick_count_ff + 8'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_count_ff <= ptimer_pkg::TICK_COUNT_RST;
    end else begin
      tick_count_ff <= nxt_tick_count;
    end
  end

  always_comb begin
    nxt_period_value = period_value_ff;
    if (wr_period) begin
      nxt_period_value = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_value_ff <= ptimer_pkg::PERIOD_VALUE_RST;
    end else begin
      period_value_ff <= nxt_period_value;
    end
  end

  // ---- postscaler ----

  // each wrap is one match for the postscaler
  match_postscaler u_postscaler (
    .pclk(pclk),
    .presetn(presetn),
    .clear(scaler_clear),
    .advance(wrap_evt),
    .sel(ctrl_ff.postscale_select),
    .post_pulse(post_pulse)
  );

  // ---- match flag ----

  // set wins over a same-cycle clear, so no event is lost
  always_comb begin
    nxt_match_irq_flag = match_irq_flag_ff;
    if (post_pulse) begin
      nxt_match_irq_flag = 1'b1;
    // software clears with a zero; a written one is ignored
    end else if (wr_flag && !pwdata[ptimer_pkg::MATCH_FLAG_POS]) begin
      nxt_match_irq_flag = 1'b0;
    end
  end

  // flag flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_irq_flag_ff <= 1'b0;
    end else begin
      match_irq_flag_ff <= nxt_match_irq_flag;
    end
  end
  assign match_irq_flag = match_irq_flag_ff;

  // ---- checks ----

  // each check samples values from before the edge, so |=> compares a flop
  // with the inputs that stood at the edge which loaded it; all of them
  // are off while presetn is low

  chk_count_increment: assert property (@(posedge pclk) disable iff (!presetn)
    presc_pulse && !wr_tick && !period_hit |=> tick_count_ff == $past(tick_count_ff) + 8'h01)
    else $error("count did not increment on prescaler pulse");

  chk_wrap_zero: assert property (@(posedge pclk) disable iff (!presetn)
    presc_pulse && !wr_tick && tick_count_ff == period_value_ff |=> tick_count_ff == 8'h00)
    else $error("count did not wrap to zero on match");

  chk_stop_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !ctrl_ff.run_bit && !wr_tick |=> $stable(tick_count_ff))
    else $error("count moved while stopped");

  chk_reset_values: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> tick_count_ff == 8'h00 && period_value_ff == 8'hFF)
    else $error("wrong values after reset");

  chk_ctrl_keeps_count: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl && !presc_pulse |=> tick_count_ff == $past(tick_count_ff))
    else $error("control write changed count");

  chk_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    post_pulse |=> match_irq_flag)
    else $error("flag not set by postscaler");

  chk_flag_cause: assert property (@(posedge pclk) disable iff (!presetn)
    !match_irq_flag && !post_pulse |=> !match_irq_flag)
    else $error("flag set without postscaled match");

  chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    match_irq_flag && !wr_flag |=> match_irq_flag)
    else $error("flag dropped without software clear");

  chk_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    wr_flag && !pwdata[ptimer_pkg::MATCH_FLAG_POS] && !post_pulse |=> !match_irq_flag)
    else $error("flag not cleared by zero write");

  chk_write_count: assert property (@(posedge pclk) disable iff (!presetn)
    wr_tick |=> tick_count_ff == $past(pwdata[7:0]))
    else $error("count write not stored");

  chk_write_period: assert property (@(posedge pclk) disable iff (!presetn)
    wr_period |=> period_value_ff == $past(pwdata[7:0]))
    else $error("period write not stored");

  chk_read_period: assert property (@(posedge pclk) disable iff (!presetn)
    setup_rd && reg_hit(paddr, ptimer_pkg::PERIOD_VALUE_ADDR) |=> prdata[7:0] == $past(period_value_ff))
    else $error("period read word wrong");

  chk_ctrl_store: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> 7'(ctrl_ff) == $past(pwdata[ptimer_pkg::CTRL_USED_BITS-1:0]))
    else $error("control write not stored");

  chk_clear_wins: assert property (@(posedge pclk) disable iff (!presetn)
    scaler_clear |-> !presc_pulse && !post_pulse)
    else $error("scaler pulse during clear");

  chk_pulse_spacing: assert property (@(posedge pclk) disable iff (!presetn)
    presc_pulse |=> !presc_pulse [*3])
    else $error("prescaler pulses closer than one instruction cycle");

  chk_div1_rate: assert property (@(posedge pclk) disable iff (!presetn)
    presc_pulse && ctrl_ff.prescale_select == ptimer_pkg::PRESCALE_DIV1
    ##1 (ctrl_ff.run_bit && !scaler_clear) [*4] |-> presc_pulse)
    else $error("divide by one not every instruction cycle");

  chk_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
    acc_phase && !pwrite && reg_hit(paddr, ptimer_pkg::TIMER_CONTROL_ADDR)
    |-> prdata[31:7] == 25'h0000000)
    else $error("control bit 7 read nonzero");

  // main scenarios the bench should reach
  cov_wrap: cover property (@(posedge pclk) disable iff (!presetn) wrap_evt);
  cov_flag_set: cover property (@(posedge pclk) disable iff (!presetn) $rose(match_irq_flag));
  cov_post16: cover property (@(posedge pclk) disable iff (!presetn)
    post_pulse && ctrl_ff.postscale_select == 4'hF);
  cov_set_vs_clear: cover property (@(posedge pclk) disable iff (!presetn)
    post_pulse && wr_flag);
  cov_div16: cover property (@(posedge pclk) disable iff (!presetn)
    presc_pulse && ctrl_ff.prescale_select[1]);

endmodule

// file: dv/period_timer_8bit_test.sv
// self-checking apb bench for the 8-bit period timer
module period_timer_8bit_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic pclk = 1'b0; // oscillator clock
  logic presetn = 1'b0; // async reset, active low
  logic psel = 1'b0; // apb select
  logic penable = 1'b0; // apb access phase
  logic pwrite = 1'b0; // apb direction
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0000_0000; // apb write data
  logic [31:0] prdata; // apb read data
  logic pready; // apb ready
  logic pslverr; // apb error
  logic match_irq_flag; // sticky match flag
  int error_cnt = 0; // mismatches seen
  int checks_done = 0; // comparisons made
  logic [31:0] rd; // word from the last transfer
  logic [31:0] held; // count seen just after a stop
  logic err_seen; // pslverr from the last transfer
  int ratio; // prescale ratio under test
  int n; // bounded wait counter

  // free-running 125 MHz clock
  always #(ptimer_pkg::PCLK_PERIOD_NS / 2) pclk = ~pclk;

  period_timer_8bit dut_u (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .match_irq_flag(match_irq_flag)
  );

  // value compare, four-state exact
  task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  // range compare, for counts that depend on the free instruction phase
  task automatic cmp_rng(input logic [31:0] got, input int lo, input int hi, input string what);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h want %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // single flag compare
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge, leaves one idle cycle
  task automatic apb_xfer(input logic wr_en, input logic [11:0] addr, input logic [31:0] wdata);
    int w;
    w = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // hold the request until ready is seen at an edge
    while (pready !== 1'b1 && w < 50) begin
      @(posedge pclk);
      w++;
    end
    if (w >= 50) cmp_bit(1'b0, 1'b1, "no pready");
    rd = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [11:0] addr, input logic [31:0] wdata);
    apb_xfer(1'b1, addr, wdata);
  endtask

  task automatic rdr(input logic [11:0] addr);
    apb_xfer(1'b0, addr, 32'h0000_0000);
  endtask

  // reset held six cycles, released on an edge
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
  endtask

  // reset contents of all registers
  task automatic check_reset();
    cmp_bit(match_irq_flag, 1'b0, "flag after reset");
    rdr(ptimer_pkg::TICK_COUNT_ADDR);
    cmp_val(rd, 32'h0000_0000, "count reset");
    rdr(ptimer_pkg::PERIOD_VALUE_ADDR);
    cmp_val(rd, 32'h0000_00FF, "period reset");
    rdr(ptimer_pkg::TIMER_CONTROL_ADDR);
    cmp_val(rd, 32'h0000_0000, "control reset");
  endtask

  // verdict and end of run
  task automatic wrap_up();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // watchdog: tests need roughly 4500 cycles
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    $display("CHECK FAILED at %0t: timeout", $time);
    wrap_up();
  end

  initial begin
    do_reset();
    check_reset();
    // full-width access and the unused control bit
    wr(ptimer_pkg::TICK_COUNT_ADDR, 32'h0000_00A5);
    rdr(ptimer_pkg::TICK_COUNT_ADDR);
    cmp_val(rd, 32'h0000_00A5, "count rw");
    cmp_bit(err_seen, 1'b0, "mapped error");
    wr(ptimer_pkg::PERIOD_VALUE_ADDR, 32'h0000_005A);
    rdr(ptimer_pkg::PERIOD_VALUE_ADDR);
    cmp_val(rd, 32'h0000_005A, "period rw");
    wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_00FB);
    rdr(ptimer_pkg::TIMER_CONTROL_ADDR);
    cmp_val(rd, 32'h0000_007B, "control bit 7");
    rdr(ptimer_pkg::TICK_COUNT_ADDR);
    cmp_val(rd, 32'h0000_00A5, "count after control write");
    // unmapped space reads zero with an error response
    rdr(12'h010);
    cmp_val(rd, 32'h0000_0000, "unmapped read");
    cmp_bit(err_seen, 1'b1, "unmapped error");
    wr(12'h010, 32'h0000_00FF);
    cmp_bit(err_seen, 1'b1, "unmapped write error");
    // every prescale code: eight increments expected per window
    wr(ptimer_pkg::PERIOD_VALUE_ADDR, 32'h0000_00FF);
    for (int s = 0; s < 4; s++) begin
      ratio = (s == 0) ? 1 : ((s == 1) ? 4 : 16);
      wr(ptimer_pkg::TICK_COUNT_ADDR, 32'h0000_0000);
      wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_0004 | 32'(s));
      repeat (8 * ptimer_pkg::OSC_PER_INSTR * ratio) @(posedge pclk);
      wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'(s));
      rdr(ptimer_pkg::TICK_COUNT_ADDR);
      cmp_rng(rd, 7, 10, "prescaled count");
      held = rd;
      repeat (100) @(posedge pclk);
      rdr(ptimer_pkg::TICK_COUNT_ADDR);
      cmp_val(rd, held, "count while stopped");
    end
    // every postscale code with period 3 and no prescale
    wr(ptimer_pkg::PERIOD_VALUE_ADDR, 32'h0000_0003);
    for (int p = 0; p < 16; p++) begin
      wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_0000);
      wr(ptimer_pkg::IRQ_FLAG_ADDR, 32'h0000_0000);
      cmp_bit(match_irq_flag, 1'b0, "flag cleared");
      wr(ptimer_pkg::TICK_COUNT_ADDR, 32'h0000_0000);
      wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_0004 | 32'(p << 3));
      // a match every 16 pclk, the flag after p+1 of them
      repeat ((p + 1) * 16 - 8) @(posedge pclk);
      cmp_bit(match_irq_flag, 1'b0, "flag early");
      n = 0;
      while (match_irq_flag !== 1'b1 && n < 16) begin
        @(posedge pclk);
        n++;
      end
      cmp_bit(match_irq_flag, 1'b1, "flag late");
      wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_0000);
      rdr(ptimer_pkg::TICK_COUNT_ADDR);
      cmp_rng(rd, 0, 3, "count wraps at period");
    end
    // flag stays set until a zero is written
    repeat (40) @(posedge pclk);
    cmp_bit(match_irq_flag, 1'b1, "flag held");
    wr(ptimer_pkg::IRQ_FLAG_ADDR, 32'h0000_0001);
    rdr(ptimer_pkg::IRQ_FLAG_ADDR);
    cmp_val(rd, 32'h0000_0001, "flag after write one");
    wr(ptimer_pkg::IRQ_FLAG_ADDR, 32'h0000_0000);
    cmp_bit(match_irq_flag, 1'b0, "flag write zero");
    // count write restarts the divide-by-16 prescaler
    wr(ptimer_pkg::PERIOD_VALUE_ADDR, 32'h0000_00FF);
    wr(ptimer_pkg::TICK_COUNT_ADDR, 32'h0000_0000);
    wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_0006);
    repeat (52) @(posedge pclk);
    wr(ptimer_pkg::TICK_COUNT_ADDR, 32'h0000_0010);
    repeat (40) @(posedge pclk);
    rdr(ptimer_pkg::TICK_COUNT_ADDR);
    cmp_val(rd, 32'h0000_0010, "prescaler not cleared");
    // control rewrite after one match restarts the 1:2 postscaler
    wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_0000);
    wr(ptimer_pkg::PERIOD_VALUE_ADDR, 32'h0000_0003);
    wr(ptimer_pkg::TICK_COUNT_ADDR, 32'h0000_0000);
    wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_000C);
    repeat (22) @(posedge pclk);
    wr(ptimer_pkg::TIMER_CONTROL_ADDR, 32'h0000_000C);
    repeat (14) @(posedge pclk);
    cmp_bit(match_irq_flag, 1'b0, "postscaler not cleared");
    n = 0;
    while (match_irq_flag !== 1'b1 && n < 30) begin
      @(posedge pclk);
      n++;
    end
    cmp_bit(match_irq_flag, 1'b1, "two matches after rewrite");
    // reset in mid-run restores every register
    wr(ptimer_pkg::PERIOD_VALUE_ADDR, 32'h0000_0022);
    do_reset();
    check_reset();
    wrap_up();
  end
endmodule
